// ### sccc_pkg.sv
// Purpose: Shared constants for the converter core control block
// Assumes: 25 MHz reference clock (40 ns period)
// Notes:   Conversion time limits are in nanoseconds; cycle counts derive from them

package sccc_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_CONV_MIN_NS = 300;
  localparam int T_CONV_MAX_NS = 340;
  // Least time rounds up, longest rounds down
  localparam int CONV_MIN_CYC  = (T_CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_MAX_CYC  = T_CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int CNT_W         = 4;

  // ****************************************************************
  // Result coding
  // ****************************************************************
  localparam int            RES_W    = 18;
  localparam logic [17:0]   CODE_ZERO    = 18'h00000;
  localparam logic [17:0]   CODE_NEG_FS  = 18'h20000;
  localparam logic [17:0]   CODE_POS_FS  = 18'h1FFFF;

  // ****************************************************************
  // Oscillator jitter source (LFSR)
  // ****************************************************************
  localparam logic [7:0]    LFSR_SEED = 8'hA5;

  // ****************************************************************
  // Data transfer clock sources
  // ****************************************************************
  typedef enum logic [1:0] {
    SCCC_XCLK_OSC  = 2'b00,
    SCCC_XCLK_HOST = 2'b01,
    SCCC_XCLK_MIX  = 2'b10
  } sccc_xclk_e;

  // ****************************************************************
  // Core states
  // ****************************************************************
  typedef enum logic [1:0] {
    SCCC_ACQ = 2'b00,
    SCCC_CNV = 2'b01
  } sccc_state_e;

endpackage : sccc_pkg

// ### sccc_osc_if.sv
// Purpose: Carries the internal oscillator timing between core modules
// Assumes: Single clock domain
// Notes:   Timer is started by the controller, reports end of conversion

`timescale 1ns/1ps

interface sccc_osc_if;
  logic start;  // One-cycle pulse: begin timing
  logic abort;  // Level: cancel timing
  logic done;   // One-cycle pulse: conversion time elapsed
  logic tick;   // Oscillator tick, usable as transfer clock

  modport ctrl  (output start, output abort, input done, input tick);
  modport timer (input start, input abort, output done, output tick);
endinterface : sccc_osc_if

// ### sccc_osc_timer.sv
// Purpose: Internal oscillator model timing each conversion
// Assumes: Clock enable gates all state
// Notes:   Length is minimum plus LFSR modulo the span; both limits are 8 cycles, so it is fixed

`timescale 1ns/1ps

module sccc_osc_timer
  import sccc_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  // Controller side
  sccc_osc_if.timer osc
);

  logic [7:0]       lfsr_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] len_q;
  logic             run_q;
  logic             done_q;
  logic             tick_q;
  logic [CNT_W-1:0] span;
  logic [CNT_W-1:0] len_d;

  // Length within the limits; the span works out to 1, so it is always 8 cycles
  assign span   = CNT_W'(CONV_MAX_CYC - CONV_MIN_CYC + 1);
  assign len_d  = CNT_W'(CONV_MIN_CYC) + (CNT_W'(lfsr_q) % span);
  assign osc.done = done_q;
  assign osc.tick = tick_q;

  // Free-running jitter source and tick
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      lfsr_q <= LFSR_SEED;
      tick_q <= 1'b0;
    end else if (CLK_EN) begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      tick_q <= ~tick_q;
    end
  end

  // Conversion counter on the reference clock, gated by the clock enable
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      run_q  <= 1'b0;
      cnt_q  <= '0;
      len_q  <= '0;
      done_q <= 1'b0;
    end else if (CLK_EN) begin
      done_q <= 1'b0;
      if (osc.abort) begin
        run_q <= 1'b0;
      end else if (osc.start) begin
        run_q <= 1'b1;
        cnt_q <= CNT_W'(1);
        len_q <= len_d;
      end else if (run_q) begin
        if (cnt_q == len_q - CNT_W'(1)) begin  // Done register adds the last cycle
          run_q  <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + CNT_W'(1);
        end
      end
    end
  end

endmodule : sccc_osc_timer

// ### sccc_core.sv
// Purpose: Control and output coding of an 18-bit SAR converter core
// Assumes: Sample stream arrives as a signed difference from the analog model
// Notes:   Start and reset come from the interface module on the same clock

`timescale 1ns/1ps

module sccc_core
  import sccc_pkg::*;
#(
  parameter int DIFF_W = 20
) (
  // Clock and reset
  input  wire logic              REF_CLK,
  input  wire logic              RST_B,
  input  wire logic              CLK_EN,
  // Control from interface module
  input  wire logic              CONVERSION_START_IN,
  input  wire logic [1:0]        XFER_CLK_SEL,
  input  wire logic              HOST_SCLK,
  // Analog difference (positive minus negative input), in steps
  input  wire logic signed [DIFF_W-1:0] INPUT_DIFF,
  // Status and result to interface module
  output logic                   CONVERSION_STATUS,
  output logic [RES_W-1:0]       RESULT,
  output logic                   SAMPLE_CONNECT,
  output logic                   XFER_CLK
);

  sccc_osc_if osc ();

  sccc_state_e           state_q;
  sccc_state_e           state_d;
  logic                  start_q;
  logic                  status_q;
  logic [RES_W-1:0]      result_q;
  logic [RES_W-1:0]      held_code_q;
  logic                  connect_q;
  logic                  xclk_q;
  logic                  sclk_s1_q;
  logic                  sclk_s2_q;
  logic                  start_edge;
  logic                  begin_cnv;
  logic                  end_cnv;
  logic                  xclk_d;
  logic [RES_W-1:0]      code_now;

  // Twos-complement coding with clamping on both ends
  function automatic logic [RES_W-1:0] code_of(input logic signed [DIFF_W-1:0] d);
    logic signed [DIFF_W-1:0] hi;
    logic signed [DIFF_W-1:0] lo;
    hi = DIFF_W'(signed'({1'b0, CODE_POS_FS}));
    lo = -hi - DIFF_W'(1);
    if (d >= hi) begin
      code_of = CODE_POS_FS;
    end else if (d <= lo) begin
      code_of = CODE_NEG_FS;
    end else begin
      code_of = d[RES_W-1:0];
    end
  endfunction : code_of

  sccc_osc_timer u_timer (
    .REF_CLK (REF_CLK),
    .RST_B   (RST_B),
    .CLK_EN  (CLK_EN),
    .osc     (osc.timer)
  );

  // ****************************************************************
  // Start detection and state control
  // ****************************************************************
  assign start_edge = CONVERSION_START_IN & ~start_q;
  assign begin_cnv  = (state_q == SCCC_ACQ) & start_edge;
  assign end_cnv    = (state_q == SCCC_CNV) & osc.done;
  assign osc.start  = begin_cnv & CLK_EN;
  assign osc.abort  = (state_q != SCCC_CNV) & ~begin_cnv;   // Timer idle outside conversions
  assign code_now   = code_of(INPUT_DIFF);

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      SCCC_ACQ: begin
        if (begin_cnv) begin
          state_d = SCCC_CNV;
        end
      end
      SCCC_CNV: begin
        if (end_cnv) begin
          state_d = SCCC_ACQ;
        end
      end
      default: state_d = SCCC_ACQ;
    endcase
  end

  // Transfer clock source selection
  always_comb begin
    case (XFER_CLK_SEL)
      SCCC_XCLK_OSC:  xclk_d = osc.tick;
      SCCC_XCLK_HOST: xclk_d = sclk_s2_q;
      SCCC_XCLK_MIX:  xclk_d = osc.tick ^ sclk_s2_q;
      default:        xclk_d = osc.tick;
    endcase
  end

  // Host clock synchroniser
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
    end else if (CLK_EN) begin
      sclk_s1_q <= HOST_SCLK;
      sclk_s2_q <= sclk_s1_q;
    end
  end

  // State, sampling and status registers
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_q     <= SCCC_ACQ;
      start_q     <= 1'b0;
      status_q    <= 1'b1;
      connect_q   <= 1'b1;
      held_code_q <= CODE_ZERO;
      result_q    <= CODE_ZERO;
      xclk_q      <= 1'b0;
    end else if (CLK_EN) begin
      state_q <= state_d;
      start_q <= CONVERSION_START_IN;
      xclk_q  <= xclk_d;
      if (begin_cnv) begin
        held_code_q <= code_now;
        connect_q   <= 1'b0;
        status_q    <= 1'b0;
      end else if (end_cnv) begin
        result_q  <= held_code_q;
        connect_q <= 1'b1;
        status_q  <= 1'b1;
      end
    end
  end

  assign CONVERSION_STATUS = status_q;
  assign RESULT            = result_q;
  assign SAMPLE_CONNECT    = connect_q;
  assign XFER_CLK          = xclk_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Enabled cycles spent with status low
  logic [CNT_W:0] busy_cnt_q;
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      busy_cnt_q <= '0;
    end else if (CLK_EN) begin
      busy_cnt_q <= status_q ? '0 : busy_cnt_q + (CNT_W+1)'(1);
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  AST_START_DROPS_STATUS: assert property (begin_cnv && CLK_EN |=> !CONVERSION_STATUS)
    else $error("status not low after start");
  AST_ISOLATED_IN_CNV: assert property (!CONVERSION_STATUS |-> !SAMPLE_CONNECT)
    else $error("inputs connected during conversion");
  AST_RECONNECT_AT_END: assert property ($rose(CONVERSION_STATUS) |-> SAMPLE_CONNECT)
    else $error("not reconnected at end");
  AST_MAX_LEN: assert property (busy_cnt_q <= (CNT_W+1)'(CONV_MAX_CYC))
    else $error("conversion too long");
  AST_MIN_LEN: assert property (
    $rose(CONVERSION_STATUS) |-> busy_cnt_q >= (CNT_W+1)'(CONV_MIN_CYC))
    else $error("conversion too short");
  AST_IGNORE_EDGES: assert property (
    state_q == SCCC_CNV && start_edge && !end_cnv && CLK_EN |=> state_q == SCCC_CNV)
    else $error("start edge not ignored");
  AST_RESULT_ONLY_AT_END: assert property (CLK_EN && !end_cnv |=> $stable(RESULT))
    else $error("result changed outside completion");
  AST_ZERO_CODE: assert property (INPUT_DIFF == '0 |-> code_now == CODE_ZERO)
    else $error("zero input not coded 00000");
  AST_SAT_POS: assert property (INPUT_DIFF >= DIFF_W'(signed'({1'b0, CODE_POS_FS}))
                                |-> code_now == CODE_POS_FS)
    else $error("positive overrange wrapped");

  // Coding table rows, status, capture and host transfer clock
  AST_NEG_SAT: assert property (
    INPUT_DIFF < -DIFF_W'(signed'({1'b0, CODE_POS_FS})) |-> code_now == CODE_NEG_FS)
    else $error("negative overrange not clamped");
  AST_NEG_PLUS_ONE: assert property (
    INPUT_DIFF == -DIFF_W'(signed'({1'b0, CODE_POS_FS})) |-> code_now == CODE_NEG_FS + RES_W'(1))
    else $error("one step above negative full scale miscoded");
  AST_MINUS_ONE_CODE: assert property (INPUT_DIFF == '1 |-> code_now == '1)
    else $error("minus one step not coded 3FFFF");
  AST_STATUS_IN_ACQ: assert property (state_q == SCCC_ACQ |-> CONVERSION_STATUS)
    else $error("status low outside conversion");
  AST_HELD_FROZEN: assert property (
    !CONVERSION_STATUS && !$past(CONVERSION_STATUS) |-> $stable(held_code_q))
    else $error("captured sample changed during conversion");
  AST_HOST_XCLK: assert property (
    XFER_CLK_SEL == SCCC_XCLK_HOST && CLK_EN |=> XFER_CLK == $past(sclk_s2_q))
    else $error("transfer clock not following host clock");

  COV_CONVERSION: cover property (begin_cnv ##[1:12] $rose(CONVERSION_STATUS));
  COV_EDGE_IGNORED: cover property (state_q == SCCC_CNV && start_edge);
  COV_NEG_FS: cover property (end_cnv && held_code_q == CODE_NEG_FS);
  COV_FROZEN_CONV: cover property (!CONVERSION_STATUS && !CLK_EN);

endmodule : sccc_core

// ### sccc_host_model.sv
// Purpose: Interface-module stand-in issuing start and reset to the core
// Assumes: Same clock as the core; drives just after the rising edge
// Notes:   Start is a level whose rising edge the core samples

`timescale 1ns/1ps

module sccc_host_model
  import sccc_pkg::*;
(
  // Clock
  input  wire logic REF_CLK,
  // Control to core
  output logic      START,
  output logic      RST_B
);
  // ****************************************************************
  // Control levels
  // ****************************************************************
  initial begin
    START = 1'b0;
    RST_B = 1'b0;
  end

  // Release reset after n edges
  task automatic release_after(input int n);
    repeat (n) @(posedge REF_CLK);
    #2 RST_B = 1'b1;
  endtask : release_after

  // Reset low for two edges, aborting any conversion
  task automatic pulse_reset();
    @(posedge REF_CLK);
    #2 RST_B = 1'b0;
    repeat (2) @(posedge REF_CLK);
    #2 RST_B = 1'b1;
  endtask : pulse_reset

  // One rising edge of start, low again after one cycle
  task automatic start_edge();
    @(posedge REF_CLK);
    #2 START = 1'b1;
    @(posedge REF_CLK);
    #2 START = 1'b0;
  endtask : start_edge

  // Level set by the caller, already off the edge
  task automatic set_start(input logic v);
    START = v;
  endtask : set_start
endmodule : sccc_host_model

// ### tb.sv
// Purpose: Self-checking bench of the converter core control
// Assumes: 40 ns clock; inputs driven 2 ns after the rising edge
// Notes:   Expected codes come from an integer model and a queue

`timescale 1ns/1ps

module tb
  import sccc_pkg::*;
;
  logic               ref_clk = 1'b0;
  logic               clk_en  = 1'b1;
  logic [1:0]         sel     = 2'b00;
  logic               host_sclk = 1'b0;
  logic signed [19:0] diff    = '0;
  wire logic          start;
  wire logic          rst_b;
  wire logic          status;
  wire logic [17:0]   result;
  wire logic          connect;
  wire logic          xclk;
  int                 n_errors = 0;
  int                 compares = 0;
  int                 seed = 55587;
  int                 cyc  = 0;
  logic [17:0]        exp_q[$];
  logic               a;

  // ****************************************************************
  // Clock, timeout and instances
  // ****************************************************************
  always #20 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      end_sim();
    end
  end

  sccc_host_model u_sccc_host_model (.REF_CLK(ref_clk), .START(start), .RST_B(rst_b));

  sccc_core u_sccc_core (
    .REF_CLK(ref_clk), .RST_B(rst_b), .CLK_EN(clk_en), .CONVERSION_START_IN(start),
    .XFER_CLK_SEL(sel), .HOST_SCLK(host_sclk), .INPUT_DIFF(diff),
    .CONVERSION_STATUS(status), .RESULT(result), .SAMPLE_CONNECT(connect), .XFER_CLK(xclk)
  );

  // ****************************************************************
  // Model and compare tasks
  // ****************************************************************
  function automatic logic [17:0] exp_code(input int d);
    if (d >= 131071) return 18'h1FFFF;
    if (d <= -131072) return 18'h20000;
    return d[17:0];
  endfunction : exp_code

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_code(input logic [17:0] got, input logic [17:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t result %h expected %h", $time, got, exp);
    end
  endtask : chk_code

  // One conversion; inputs and start toggle while it runs, fr freezes 3 edges
  task automatic run_conv(input logic signed [19:0] d, input bit fr);
    int n;
    int lo;
    diff = d;
    exp_q.push_back(exp_code(int'(d)));
    lo = CONV_MIN_CYC + (fr ? 3 : 0);
    u_sccc_host_model.start_edge();
    n = 0;
    while (status !== 1'b1 && n < 30) begin
      @(posedge ref_clk);
      #2 n++;
      clk_en = !(fr && n >= 4 && n < 7);
      if (n == 1) chk_bit(connect, 1'b0);
      if (n == 1) chk_bit(status, 1'b0);
      if (n == 1) diff = 20'($random(seed));
      u_sccc_host_model.set_start(n == 2 || n == 3);
    end
    chk_bit(n >= lo && n <= lo + CONV_MAX_CYC - CONV_MIN_CYC, 1'b1);
    chk_bit(connect, 1'b1);
    chk_code(result, exp_q.pop_front());
  endtask : run_conv

  task automatic end_sim();
    if (n_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    u_sccc_host_model.release_after(4);
    chk_bit(status, 1'b1);
    chk_bit(connect, 1'b1);
    chk_code(result, 18'h00000);
    // Coding table corners, then random differences
    run_conv(20'sd0, 1'b0);
    run_conv(-20'sd1, 1'b0);
    run_conv(-20'sd131072, 1'b0);
    run_conv(-20'sd300000, 1'b0);
    run_conv(-20'sd131071, 1'b0);
    run_conv(20'sd131070, 1'b1);
    run_conv(20'sd131071, 1'b0);
    run_conv(20'sd400000, 1'b0);
    repeat (6) run_conv(20'($random(seed)), 1'b0);
    // Reset during a conversion
    u_sccc_host_model.start_edge();
    u_sccc_host_model.pulse_reset();
    chk_bit(status, 1'b1);
    chk_bit(connect, 1'b1);
    chk_code(result, 18'h00000);
    run_conv(20'sd5, 1'b0);
    // Transfer clock from the host, then oscillator-based selections
    sel = 2'b01;
    host_sclk = 1'b1;
    repeat (5) @(posedge ref_clk);
    #2 chk_bit(xclk, 1'b1);
    host_sclk = 1'b0;
    repeat (5) @(posedge ref_clk);
    #2 chk_bit(xclk, 1'b0);
    for (int s = 0; s < 4; s++) begin
      if (s != 1) begin
        sel = s[1:0];
        repeat (4) @(posedge ref_clk);
        #2 a = xclk;
        @(posedge ref_clk);
        #2 chk_bit(xclk !== a, 1'b1);
      end
    end
    end_sim();
  end
endmodule : tb
